// *** core/drcot_params.svh ***
// Mode register addresses, field positions, reset values and counts
`ifndef DRCOT_PARAMS_SVH
`define DRCOT_PARAMS_SVH
`define DRCOT_ADDR_INVERT    6'h14
`define DRCOT_ADDR_RSVD      6'h15
`define DRCOT_ADDR_TERM      6'h16
`define DRCOT_ADDR_RUNTIME   6'h17
`define DRCOT_ADDR_TRR       6'h18
`define DRCOT_INVERT_RESET   8'h55
`define DRCOT_TERM_RESET     6'h00
`define DRCOT_RUNTIME_RESET  8'h00
`define DRCOT_RUNTIME_MAX    8'h04
`define DRCOT_OSC_STEP_LSB   4
`define DRCOT_MPC_CAL_READ   7'h43
`define DRCOT_MPC_OSC_STOP   7'h4D
`define DRCOT_MPC_OSC_START  7'h4B
`define DRCOT_CAL_LAST       4'hF
`define DRCOT_MAC_VALUE      3'h0
`define DRCOT_MAC_UNLIMITED  1'h0
`define DRCOT_TERM_CTV_MSB   2
`define DRCOT_TERM_CK_BIT    3
`define DRCOT_TERM_CS_BIT    4
`define DRCOT_TERM_CA_BIT    5
`define DRCOT_TRR_EN_BIT     7
`endif

// *** core/drcot_pkg.sv ***
// Types shared by the mode register block
package drcot_pkg;
    typedef enum logic {OSC_IDLE, OSC_RUN} drcot_osc_t;
    typedef enum logic {CAL_IDLE, CAL_SHIFT} drcot_cal_t;
endpackage : drcot_pkg

// *** core/drcot_regs.sv ***
// Calibration invert, termination, DQS timer and row refresh mode registers
`include "drcot_params.svh"
`timescale 1ns/1ps
`default_nettype none
module drcot_regs
    import drcot_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       link_clk,
    input  wire logic       mrw_valid,
    input  wire logic       mrr_valid,
    input  wire logic [5:0] mr_addr,
    input  wire logic [7:0] mr_wdata,
    input  wire logic       mpc_valid,
    input  wire logic [6:0] mpc_op,
    input  wire logic       write_set_point_select,
    input  wire logic       operating_set_point_select,
    output logic      [7:0] mrr_rdata,
    output logic            mrr_rvalid,
    output logic            mrr_hit,
    output logic      [2:0] controller_termination_value,
    output logic            clock_termination_disable,
    output logic            chip_select_termination_disable,
    output logic            command_address_termination_disable,
    output logic            target_row_refresh_enable,
    output logic      [2:0] target_row_refresh_bank,
    output logic            dqs_osc_running,
    input  wire logic [7:0] calibration_pattern_a,
    input  wire logic [7:0] calibration_pattern_b,
    input  wire logic       read_dbi_enable,
    output logic            cal_active,
    output logic      [7:0] dq_upper_out,
    output logic            upper_mask_inversion_lane_out,
    output logic            upper_mask_inversion_lane_oe,
    output logic            dbi_applied
);
    // Link domain: all mode register state lives on the controller's clock
    logic [7:0] invert_mask;
    logic       inv_toggle;
    logic       cal_toggle;
    logic [5:0] term_copy [2];
    logic [7:0] run_time;
    drcot_osc_t osc_state;
    logic [6:0] osc_cnt;

    wire wr_inv  = mrw_valid && (mr_addr == `DRCOT_ADDR_INVERT);
    wire wr_term = mrw_valid && (mr_addr == `DRCOT_ADDR_TERM);
    wire wr_run  = mrw_valid && (mr_addr == `DRCOT_ADDR_RUNTIME);
    wire wr_trr  = mrw_valid && (mr_addr == `DRCOT_ADDR_TRR);
    wire mpc_cal   = mpc_valid && (mpc_op == `DRCOT_MPC_CAL_READ);
    wire mpc_start = mpc_valid && (mpc_op == `DRCOT_MPC_OSC_START);
    wire mpc_stop  = mpc_valid && (mpc_op == `DRCOT_MPC_OSC_STOP);

    // Reserved slot has no storage, so writes there simply vanish
    wire        addr_ours = (mr_addr >= `DRCOT_ADDR_INVERT) && (mr_addr <= `DRCOT_ADDR_TRR);
    wire [5:0]  term_wsel = term_copy[write_set_point_select];
    wire [5:0]  term_osel = term_copy[operating_set_point_select];
    wire        unlim     = `DRCOT_MAC_UNLIMITED;
    wire [2:0]  mac_rd    = unlim ? 3'h0 : `DRCOT_MAC_VALUE;
    wire [7:0]  rd_term   = {2'h0, term_wsel};
    wire [7:0]  rd_trr    = {4'h0, unlim, mac_rd};
    // Write-only fields read back as zero; only readable state is returned
    wire [7:0]  next_rdata = (mr_addr == `DRCOT_ADDR_TERM) ? rd_term :
                             (mr_addr == `DRCOT_ADDR_TRR)  ? rd_trr  : 8'h00;

    // Values above the top code are reserved: the timer then runs on and ignores command stop
    wire        osc_auto  = (run_time != 8'h00) && (run_time <= `DRCOT_RUNTIME_MAX);
    wire [6:0]  osc_limit = {run_time[2:0], 4'h0};
    wire [6:0]  osc_cnt_inc = osc_cnt + 7'h01;
    wire        osc_done  = osc_auto ? (osc_cnt_inc == osc_limit)
                                     : ((run_time == 8'h00) && mpc_stop);

    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            invert_mask <= `DRCOT_INVERT_RESET;
            inv_toggle  <= 1'b0;
            cal_toggle  <= 1'b0;
            run_time    <= `DRCOT_RUNTIME_RESET;
        end
        else
        begin
            if (wr_inv)
            begin
                invert_mask <= mr_wdata;
                inv_toggle  <= ~inv_toggle;
            end
            if (mpc_cal)
                cal_toggle <= ~cal_toggle;
            if (wr_run)
                run_time <= mr_wdata;
        end
    end

    // One storage copy per frequency set point
    genvar sp;
    generate
        for (sp = 0; sp < 2; sp++)
        begin : g_set_point
            always_ff @(posedge link_clk or negedge reset_n)
            begin
                if (!reset_n)
                    term_copy[sp] <= `DRCOT_TERM_RESET;
                else if (wr_term && (write_set_point_select == 1'(sp)))
                    term_copy[sp] <= mr_wdata[5:0];
            end
        end
    endgenerate

    // No pad input exists: termination follows the registers alone
    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            controller_termination_value        <= 3'h0;
            clock_termination_disable           <= 1'b0;
            chip_select_termination_disable     <= 1'b0;
            command_address_termination_disable <= 1'b0;
        end
        else
        begin
            controller_termination_value        <= term_osel[`DRCOT_TERM_CTV_MSB:0];
            clock_termination_disable           <= term_osel[`DRCOT_TERM_CK_BIT];
            chip_select_termination_disable     <= term_osel[`DRCOT_TERM_CS_BIT];
            command_address_termination_disable <= term_osel[`DRCOT_TERM_CA_BIT];
        end
    end

    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            target_row_refresh_enable <= 1'b0;
            target_row_refresh_bank   <= 3'h0;
        end
        else if (wr_trr)
        begin
            target_row_refresh_enable <= mr_wdata[`DRCOT_TRR_EN_BIT];
            target_row_refresh_bank   <= mr_wdata[6:4];
        end
    end

    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mrr_rdata  <= 8'h00;
            mrr_rvalid <= 1'b0;
            mrr_hit    <= 1'b0;
        end
        else
        begin
            mrr_rvalid <= mrr_valid;
            mrr_hit    <= mrr_valid && addr_ours;
            if (mrr_valid)
                mrr_rdata <= next_rdata;
        end
    end

    // A start while running is ignored rather than restarting the count
    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            osc_state <= OSC_IDLE;
            osc_cnt   <= 7'h00;
        end
        else
        begin
            case (osc_state)
                OSC_IDLE:
                begin
                    osc_cnt <= 7'h00;
                    if (mpc_start)
                        osc_state <= OSC_RUN;
                end
                OSC_RUN:
                begin
                    osc_cnt <= osc_cnt_inc;
                    if (osc_done)
                        osc_state <= OSC_IDLE;
                end
                default:
                    osc_state <= OSC_IDLE;
            endcase
        end
    end

    assign dqs_osc_running = (osc_state == OSC_RUN);

    // Core domain: toggles cross on three flops, settled when two agree
    logic [2:0] inv_sync;
    logic [2:0] cal_sync;
    logic       inv_seen;
    logic       cal_seen;
    logic [7:0] core_invert;
    drcot_cal_t cal_state;
    logic [3:0] cal_idx;

    wire inv_event = (inv_sync[1] == inv_sync[2]) && (inv_sync[2] != inv_seen);
    wire cal_event = (cal_sync[1] == cal_sync[2]) && (cal_sync[2] != cal_seen);
    // Mask is stable long before the toggle settles, given mode write spacing
    wire [7:0] cal_byte = cal_idx[3] ? calibration_pattern_b : calibration_pattern_a;
    wire       pat_bit  = cal_byte[cal_idx[2:0]];
    // Flags follow the shift state so each flagged cycle carries its own bit
    wire       next_cal = (cal_state == CAL_SHIFT);

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            inv_sync    <= 3'h0;
            cal_sync    <= 3'h0;
            inv_seen    <= 1'b0;
            cal_seen    <= 1'b0;
            core_invert <= `DRCOT_INVERT_RESET;
        end
        else
        begin
            inv_sync <= {inv_sync[1:0], inv_toggle};
            cal_sync <= {cal_sync[1:0], cal_toggle};
            if (inv_event)
            begin
                inv_seen    <= inv_sync[2];
                core_invert <= invert_mask;
            end
            if (cal_event)
                cal_seen <= cal_sync[2];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cal_state <= CAL_IDLE;
            cal_idx   <= 4'h0;
        end
        else
        begin
            case (cal_state)
                CAL_IDLE:
                begin
                    cal_idx <= 4'h0;
                    if (cal_event)
                        cal_state <= CAL_SHIFT;
                end
                CAL_SHIFT:
                begin
                    cal_idx <= cal_idx + 4'h1;
                    if (cal_idx == `DRCOT_CAL_LAST)
                        cal_state <= CAL_IDLE;
                end
                default:
                    cal_state <= CAL_IDLE;
            endcase
        end
    end

    genvar ln;
    generate
        for (ln = 0; ln < 8; ln++)
        begin : g_lane
            always_ff @(posedge core_clk or negedge reset_n)
            begin
                if (!reset_n)
                    dq_upper_out[ln] <= 1'b0;
                else
                    dq_upper_out[ln] <= pat_bit ^ core_invert[ln];
            end
        end
    endgenerate

    // Mask lane carries true data, and only when read inversion is on
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cal_active                    <= 1'b0;
            upper_mask_inversion_lane_out <= 1'b0;
            upper_mask_inversion_lane_oe  <= 1'b0;
            dbi_applied                   <= 1'b0;
        end
        else
        begin
            cal_active                    <= next_cal;
            upper_mask_inversion_lane_out <= pat_bit;
            upper_mask_inversion_lane_oe  <= next_cal && read_dbi_enable;
            dbi_applied                   <= read_dbi_enable && !next_cal;
        end
    end

    AST_RSVD_READ_ZERO: assert property (@(posedge link_clk) disable iff (!reset_n)
        mrr_valid && (mr_addr == `DRCOT_ADDR_RSVD) |=> (mrr_rdata == 8'h00) && mrr_hit)
        else $error("reserved slot read not zero");
    AST_TERM_WRITE_SEL: assert property (@(posedge link_clk) disable iff (!reset_n)
        wr_term && !write_set_point_select |=>
        (term_copy[0] == $past(mr_wdata[5:0])) && (term_copy[1] == $past(term_copy[1])))
        else $error("termination write reached wrong copy");
    AST_TERM_OPERATING: assert property (@(posedge link_clk) disable iff (!reset_n)
        1'b1 |=> command_address_termination_disable ==
        $past(term_copy[operating_set_point_select][`DRCOT_TERM_CA_BIT]))
        else $error("termination not from operating copy");
    AST_MAC_UNLIMITED: assert property (@(posedge link_clk) disable iff (!reset_n)
        mrr_valid && (mr_addr == `DRCOT_ADDR_TRR) |=> !mrr_rdata[3] || (mrr_rdata[2:0] == 3'h0))
        else $error("activate count nonzero with unlimited flag");
    AST_OSC_AUTO16: assert property (@(posedge link_clk) disable iff (!reset_n)
        mpc_start && !dqs_osc_running && (run_time == 8'h01) && !wr_run |=>
        dqs_osc_running [*8] ##1 dqs_osc_running [*8] ##1 !dqs_osc_running)
        else $error("timer did not stop after 16 clocks");
    AST_OSC_MPC_STOP: assert property (@(posedge link_clk) disable iff (!reset_n)
        dqs_osc_running && (run_time == 8'h00) && mpc_stop |=> !dqs_osc_running)
        else $error("stop command ignored");
    AST_TRR_ENABLE: assert property (@(posedge link_clk) disable iff (!reset_n)
        wr_trr |=> target_row_refresh_enable == $past(mr_wdata[7]))
        else $error("refresh enable not written");
    AST_TRR_BANK: assert property (@(posedge link_clk) disable iff (!reset_n)
        wr_trr |=> target_row_refresh_bank == $past(mr_wdata[6:4]))
        else $error("refresh bank not written");
    AST_LANE_INVERT: assert property (@(posedge core_clk) disable iff (!reset_n)
        cal_state == CAL_SHIFT |=> dq_upper_out == ({8{$past(pat_bit)}} ^ $past(core_invert)))
        else $error("lane inversion wrong");
    AST_MASK_LANE_TRUE: assert property (@(posedge core_clk) disable iff (!reset_n)
        cal_state == CAL_SHIFT |=> upper_mask_inversion_lane_out == $past(pat_bit))
        else $error("mask lane inverted");
    AST_NO_DBI_CAL: assert property (@(posedge core_clk) disable iff (!reset_n)
        cal_active |-> !dbi_applied)
        else $error("inversion applied during calibration");
    AST_CAL_LENGTH: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(cal_active) |-> cal_active [*8] ##1 cal_active [*8] ##1 !cal_active)
        else $error("calibration burst not 16 bits");

    COV_CAL_BURST: cover property (@(posedge core_clk) disable iff (!reset_n) $fell(cal_active));
    COV_OSC_AUTO: cover property (@(posedge link_clk) disable iff (!reset_n)
        osc_auto && $fell(dqs_osc_running));
    COV_TERM_SP1: cover property (@(posedge link_clk) disable iff (!reset_n)
        wr_term && write_set_point_select);
endmodule : drcot_regs
`default_nettype wire

// *** bench/drcot_ctrl_model.sv ***
// Memory controller model issuing mode register commands on the link clock
`timescale 1ns/1ps
`default_nettype none
module drcot_ctrl_model (
    input  wire logic       link_clk,
    output var  logic       mrw_valid,
    output var  logic       mrr_valid,
    output var  logic [5:0] mr_addr,
    output var  logic [7:0] mr_wdata,
    output var  logic       mpc_valid,
    output var  logic [6:0] mpc_op,
    output var  logic       write_set_point_select,
    output var  logic       operating_set_point_select,
    input  wire logic [7:0] mrr_rdata,
    input  wire logic       mrr_rvalid,
    input  wire logic       mrr_hit
);
    logic       slow = 1'b0;
    logic       io_supply_high = 1'b1;
    logic [7:0] run_time_copy = 8'h00;

    initial
    begin
        {mrw_valid, mrr_valid, mpc_valid} = 3'h0;
        {mr_addr, mr_wdata, mpc_op} = 21'h0;
        {write_set_point_select, operating_set_point_select} = 2'h0;
    end

    task automatic begin_cmd();
        if (slow)
            repeat (2) @(negedge link_clk);
        @(negedge link_clk);
    endtask : begin_cmd

    // Released lines show inverted data, so a stale value never passes
    task automatic end_cmd();
        @(posedge link_clk);
        @(negedge link_clk);
        {mrw_valid, mrr_valid, mpc_valid} = 3'h0;
        mr_addr  = ~mr_addr;
        mr_wdata = ~mr_wdata;
        mpc_op   = ~mpc_op;
    endtask : end_cmd

    // No command/address termination enable is modelled, so settings come first
    task automatic mrw(input logic [5:0] addr, input logic [7:0] data);
        if (addr == 6'h16 && !io_supply_high && data[2:0] inside {3'h1, 3'h3, 3'h5, 3'h6})
            return;
        if (addr == 6'h17)
            run_time_copy = data;
        begin_cmd();
        mrw_valid = 1'b1;
        mr_addr   = addr;
        mr_wdata  = data;
        end_cmd();
    endtask : mrw

    task automatic mrr(input logic [5:0] addr, output logic [7:0] rd, output logic hit,
                       output logic vld);
        begin_cmd();
        mrr_valid = 1'b1;
        mr_addr   = addr;
        end_cmd();
        if (mrr_rvalid !== 1'b1)
            @(negedge link_clk);
        vld = mrr_rvalid;
        rd  = mrr_rdata;
        hit = mrr_hit;
    endtask : mrr

    task automatic mpc(input logic [6:0] op);
        if (op == 7'h4D && run_time_copy != 8'h00)
            return;
        begin_cmd();
        mpc_valid = 1'b1;
        mpc_op    = op;
        end_cmd();
    endtask : mpc

    task automatic set_sel(input logic w, input logic o);
        @(negedge link_clk);
        write_set_point_select     = w;
        operating_set_point_select = o;
    endtask : set_sel
endmodule : drcot_ctrl_model
`default_nettype wire

// *** bench/tb_dram_calib_odt_target_row_refresh_enable_regs.sv ***
// Self-checking bench for the mode register block
`timescale 1ns/1ps
`default_nettype none
module tb_dram_calib_odt_target_row_refresh_enable_regs;
    logic       core_clk = 1'b0;
    logic       link_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       mrw_valid, mrr_valid, mpc_valid;
    logic [5:0] mr_addr;
    logic [7:0] mr_wdata, mrr_rdata, dq_upper_out, rd;
    logic [6:0] mpc_op;
    logic       write_set_point_select, operating_set_point_select;
    logic       mrr_rvalid, mrr_hit, hit, vld;
    logic [2:0] controller_termination_value, target_row_refresh_bank;
    logic       clock_termination_disable, chip_select_termination_disable;
    logic       command_address_termination_disable, target_row_refresh_enable;
    logic       dqs_osc_running, cal_active, dbi_applied;
    logic       upper_mask_inversion_lane_out, upper_mask_inversion_lane_oe;
    logic [7:0] calibration_pattern_a = 8'h5A;
    logic [7:0] calibration_pattern_b = 8'h3C;
    logic       read_dbi_enable = 1'b0;
    int         miscompares = 0;
    int         compares = 0;
    wire  [7:0] term_vec = {2'h0, command_address_termination_disable,
                            chip_select_termination_disable, clock_termination_disable,
                            controller_termination_value};
    // Address, write data, expected read data
    localparam logic [21:0] rows [11] = '{
        {6'h16, 8'h00, 8'h00}, {6'h16, 8'h09, 8'h09}, {6'h14, 8'hAA, 8'h00},
        {6'h16, 8'h12, 8'h12}, {6'h16, 8'h23, 8'h23}, {6'h16, 8'hC4, 8'h04},
        {6'h16, 8'h3D, 8'h3D}, {6'h16, 8'h06, 8'h06}, {6'h18, 8'hF5, 8'h00},
        {6'h18, 8'h30, 8'h00}, {6'h15, 8'hFF, 8'h00}};

    always #5 core_clk = ~core_clk;
    initial
    begin
        #17;
        forever #40 link_clk = ~link_clk;
    end

    drcot_regs u_dut (.core_clk, .reset_n, .link_clk, .mrw_valid, .mrr_valid, .mr_addr,
        .mr_wdata, .mpc_valid, .mpc_op, .write_set_point_select, .operating_set_point_select,
        .mrr_rdata, .mrr_rvalid, .mrr_hit, .controller_termination_value,
        .clock_termination_disable, .chip_select_termination_disable,
        .command_address_termination_disable, .target_row_refresh_enable,
        .target_row_refresh_bank, .dqs_osc_running, .calibration_pattern_a,
        .calibration_pattern_b, .read_dbi_enable, .cal_active, .dq_upper_out,
        .upper_mask_inversion_lane_out, .upper_mask_inversion_lane_oe, .dbi_applied);

    drcot_ctrl_model u_ctrl (.link_clk, .mrw_valid, .mrr_valid, .mr_addr, .mr_wdata,
        .mpc_valid, .mpc_op, .write_set_point_select, .operating_set_point_select,
        .mrr_rdata, .mrr_rvalid, .mrr_hit);

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // Burst is A then B, low bit first, so pattern bit i is {B, A}[i]
    task automatic cal_run(input logic [7:0] mask, input logic dbi);
        logic [15:0] pat;
        int          n;
        pat = {calibration_pattern_b, calibration_pattern_a};
        @(negedge core_clk);
        read_dbi_enable = dbi;
        u_ctrl.mpc(7'h43);
        n = 0;
        while (cal_active !== 1'b1 && n < 60)
        begin
            @(negedge core_clk);
            n++;
        end
        for (int i = 0; i < 16; i++)
        begin
            chk(dq_upper_out, {8{pat[i]}} ^ mask);
            chk(8'(upper_mask_inversion_lane_out), 8'(pat[i]));
            chk(8'(upper_mask_inversion_lane_oe), 8'(dbi));
            chk(8'({cal_active, dbi_applied}), 8'h02);
            @(negedge core_clk);
        end
        chk(8'({cal_active, dbi_applied}), 8'(dbi));
        repeat (12) @(negedge core_clk);
    endtask : cal_run

    task automatic osc_run(input logic [7:0] exp);
        int cnt;
        u_ctrl.mpc(7'h4B);
        cnt = 0;
        while (dqs_osc_running === 1'b1 && cnt < 400)
        begin
            cnt++;
            @(negedge link_clk);
        end
        chk(8'(cnt), exp);
    endtask : osc_run

    initial
    begin
        #200000;
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        repeat (8) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge link_clk);
        chk(term_vec, 8'h00);
        chk(8'({target_row_refresh_enable, target_row_refresh_bank, dqs_osc_running}), 8'h00);
        u_ctrl.mrr(6'h18, rd, hit, vld);
        chk({vld, hit, 6'h00}, 8'hC0);
        chk(rd, 8'h00);
        u_ctrl.mrr(6'h20, rd, hit, vld);
        chk(8'(hit), 8'h00);
        cal_run(8'h55, 1'b1);
        foreach (rows[i])
        begin
            u_ctrl.mrw(rows[i][21:16], rows[i][15:8]);
            u_ctrl.mrr(rows[i][21:16], rd, hit, vld);
            chk(rd, rows[i][7:0]);
            repeat (3) @(negedge link_clk);
            if (rows[i][21:16] == 6'h16)
                chk(term_vec, {2'h0, rows[i][13:8]});
            if (rows[i][21:16] == 6'h18)
                chk(8'({target_row_refresh_enable, target_row_refresh_bank}),
                    8'(rows[i][15:12]));
        end
        cal_run(8'hAA, 1'b0);
        u_ctrl.mrw(6'h16, 8'h15);
        u_ctrl.set_sel(1'b1, 1'b0);
        u_ctrl.mrw(6'h16, 8'h2A);
        u_ctrl.mrr(6'h16, rd, hit, vld);
        chk(rd, 8'h2A);
        repeat (3) @(negedge link_clk);
        chk(term_vec, 8'h15);
        u_ctrl.set_sel(1'b0, 1'b1);
        u_ctrl.mrr(6'h16, rd, hit, vld);
        chk(rd, 8'h15);
        repeat (3) @(negedge link_clk);
        chk(term_vec, 8'h2A);
        for (int n = 1; n <= 4; n++)
        begin
            u_ctrl.slow = n[0];
            u_ctrl.mrw(6'h17, 8'(n));
            osc_run(8'(16 * n));
        end
        u_ctrl.mrw(6'h17, 8'h00);
        u_ctrl.mpc(7'h4B);
        repeat (70) @(negedge link_clk);
        chk(8'(dqs_osc_running), 8'h01);
        u_ctrl.mpc(7'h4D);
        repeat (2) @(negedge link_clk);
        chk(8'(dqs_osc_running), 8'h00);
        report_and_stop();
    end
endmodule : tb_dram_calib_odt_target_row_refresh_enable_regs
`default_nettype wire
